// ==== core/decode_consts.svh ====
// decode field positions, opcode codes and special register numbers
// assumes inclusion by core design files only
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH
`define OP_HI 31
`define OP_LO 30
`define OP3_HI 24
`define OP3_LO 19
`define RD_HI 29
`define RD_LO 25
`define SUB_HI 13
`define SUB_LO 5
`define OP2_HI 24
`define OP2_LO 22
`define COND_HI 28
`define COND_LO 25
`define RS1_HI 18
`define RS1_LO 14
`define RS2_HI 4
`define RS2_LO 0
`define IMM_BIT 13
`define SIMM_HI 12
`define ASI_HI 12
`define ASI_LO 5
`define HIC_HI 21
`define HIC_W 22
`define LOW_W 10
`define WORD_W 32
`define SIMM_W 13
`define OP3_TOP_BIT 5
`define STORE_BIT 2
`define FMT3_BIT 1
`define OP_BRANCH_GRP 2'h0
`define OP_ARITH 2'h2
`define OP_MEM 2'h3
`define OP2_UNIMPLEMENTED_FORM 3'h0
`define OP2_ICC 3'h2
`define OP2_SETHIGH 3'h4
`define OP3_JMPL 6'h38
`define OP3_RDASR 6'h28
`define OP3_WRASR 6'h30
`define ALT_SPACE_BIT 4
`define ANC_REG_NUM 5'h11
`define REG_ZERO 5'h0
`define REG_IN7 5'h1f
`define REG_OUT7 5'h0f
`define RET_OFFSET 13'h0008
`endif

// ==== core/decode_pkg.sv ====
// types shared by the decode front end
// assumes the constants header supplies the numeric codes
package decode_pkg;
  typedef enum logic [3:0] {
    br_never, br_eq, br_le, br_lt, br_leu, br_cs, br_neg, br_vs,
    br_always, br_ne, br_gt, br_ge, br_gtu, br_cc, br_pos, br_vc
  } branch_cond_t;
  typedef enum logic [1:0] {grp_global, grp_out, grp_local, grp_in} reg_group_t;
  typedef enum logic [2:0] {
    cls_other, cls_unimplemented_form, cls_branch, cls_sethigh, cls_ret, cls_retl
  } instr_class_t;
endpackage

// ==== core/reg_group_map.sv ====
// maps a 5-bit integer register number onto its window group
// assumes a purely combinational use inside the decoder
`timescale 1ns/10ps
`include "decode_consts.svh"
module reg_group_map (
  input wire logic [4:0] reg_num,
  output decode_pkg::reg_group_t group,
  output logic [2:0] index,
  output logic is_zero
);
  import decode_pkg::*;
  // upper two bits pick globals, outs, locals or ins
  assign group = reg_group_t'(reg_num[4:3]);
  assign index = reg_num[2:0];
  assign is_zero = (reg_num == `REG_ZERO);
endmodule

// ==== core/risc_format_branch_decoder.sv ====
// instruction decode front end: field split, class, branch condition
// assumes one instruction word per cycle from fetch, qualified by instr_valid
`timescale 1ns/10ps
`include "decode_consts.svh"
module risc_format_branch_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  output logic dec_valid_q,
  output logic [1:0] field1_q,
  output logic [5:0] field2_q,
  output logic [4:0] field3_q,
  output logic [8:0] field4_q,
  output decode_pkg::instr_class_t class_q,
  output decode_pkg::branch_cond_t cond_q,
  output logic branch_annul_q,
  output logic [4:0] rs1_q,
  output logic [4:0] rs2_q,
  output logic [4:0] rd_q,
  output decode_pkg::reg_group_t rs1_group_q,
  output decode_pkg::reg_group_t rs2_group_q,
  output decode_pkg::reg_group_t rd_group_q,
  output logic rs1_zero_q,
  output logic rs2_zero_q,
  output logic rd_write_q,
  output logic use_imm_q,
  output logic [31:0] imm_q,
  output logic alt_space_q,
  output logic [7:0] asi_q,
  output logic asr_access_q,
  output logic asr_illegal_q
);
  import decode_pkg::*;

  // field split in documented matching order
  wire [1:0] f1 = instr[`OP_HI:`OP_LO];
  wire [5:0] f2 = instr[`OP3_HI:`OP3_LO];
  wire [4:0] f3 = instr[`RD_HI:`RD_LO];
  wire [8:0] f4 = instr[`SUB_HI:`SUB_LO];
  wire [2:0] op2 = instr[`OP2_HI:`OP2_LO];
  wire [4:0] rs1 = instr[`RS1_HI:`RS1_LO];
  wire [4:0] rs2 = instr[`RS2_HI:`RS2_LO];
  wire imm_sel = instr[`IMM_BIT];

  // class decode: field 1 first, then field 2, then fields 3 and 4
  wire is_fmt2 = (f1 == `OP_BRANCH_GRP);
  wire is_unimplemented_form = is_fmt2 && (op2 == `OP2_UNIMPLEMENTED_FORM);
  wire is_bicc = is_fmt2 && (op2 == `OP2_ICC);
  wire is_sethi = is_fmt2 && (op2 == `OP2_SETHIGH);
  wire is_jmpl = (f1 == `OP_ARITH) && (f2 == `OP3_JMPL);
  wire jmpl_plus8 = is_jmpl && imm_sel && (f3 == `REG_ZERO)
    && (instr[`SIMM_HI:0] == `RET_OFFSET);
  wire is_ret = jmpl_plus8 && (rs1 == `REG_IN7);
  wire is_retl = jmpl_plus8 && (rs1 == `REG_OUT7);
  wire instr_class_t cls_d = is_unimplemented_form ? cls_unimplemented_form :
    is_bicc ? cls_branch :
    is_sethi ? cls_sethigh :
    is_ret ? cls_ret :
    is_retl ? cls_retl : cls_other;

  // condition code is bits 28-25; bit 29 only annuls, never classifies
  wire branch_cond_t cond_d = branch_cond_t'(instr[`COND_HI:`COND_LO]);

  // immediate: sign-extended 13-bit or set-high constant with zero low part
  wire [31:0] simm_ext = {{(`WORD_W - `SIMM_W){instr[`SIMM_HI]}}, instr[`SIMM_HI:0]};
  wire [31:0] hic_ext = {instr[`HIC_HI:0], {`LOW_W{1'b0}}};
  wire use_imm_d = is_sethi || ((f1[`FMT3_BIT]) && imm_sel);
  wire [31:0] imm_d = is_sethi ? hic_ext : simm_ext;

  // alternate-space memory ops carry asi in bits 12-5 (register form only)
  wire alt_d = (f1 == `OP_MEM) && f2[`ALT_SPACE_BIT]
    && !f2[`OP3_TOP_BIT] && !imm_sel;

  // ancillary state access: only register 17 exists; rs1 0 / rd 0 is y
  wire is_rdasr = (f1 == `OP_ARITH) && (f2 == `OP3_RDASR) && (rs1 != `REG_ZERO);
  wire is_wrasr = (f1 == `OP_ARITH) && (f2 == `OP3_WRASR) && (f3 != `REG_ZERO);
  wire [4:0] asr_num = is_rdasr ? rs1 : f3;
  wire asr_d = (is_rdasr || is_wrasr) && (asr_num == `ANC_REG_NUM);
  wire asr_bad_d = (is_rdasr || is_wrasr) && (asr_num != `ANC_REG_NUM);

  // destination writes: branches, unimplemented_form, stores and r0 never write
  wire writes_d = !is_fmt2 ? (f1 != `OP_MEM || !f2[`STORE_BIT]) : is_sethi;
  wire rd_write_d = writes_d && !is_wrasr && (f3 != `REG_ZERO);

  // register group mapping for the three operand fields
  reg_group_t g_rs1, g_rs2, g_rd;
  logic z_rs1, z_rs2;
  reg_group_map u_map_rs1 (.reg_num(rs1), .group(g_rs1), .index(), .is_zero(z_rs1));
  reg_group_map u_map_rs2 (.reg_num(rs2), .group(g_rs2), .index(), .is_zero(z_rs2));
  reg_group_map u_map_rd (.reg_num(f3), .group(g_rd), .index(), .is_zero());

  // one-stage register of all decode results; fields hold when idle
  always_ff @(posedge clk) begin
    if (srst) begin
      dec_valid_q <= 1'b0;
      field1_q <= 2'h0;
      field2_q <= 6'h00;
      field3_q <= 5'h00;
      field4_q <= 9'h000;
      class_q <= cls_other;
      cond_q <= br_never;
      branch_annul_q <= 1'b0;
      rs1_q <= 5'h00;
      rs2_q <= 5'h00;
      rd_q <= 5'h00;
      rs1_group_q <= grp_global;
      rs2_group_q <= grp_global;
      rd_group_q <= grp_global;
      rs1_zero_q <= 1'b1;
      rs2_zero_q <= 1'b1;
      rd_write_q <= 1'b0;
      use_imm_q <= 1'b0;
      imm_q <= 32'h0000_0000;
      alt_space_q <= 1'b0;
      asi_q <= 8'h00;
      asr_access_q <= 1'b0;
      asr_illegal_q <= 1'b0;
    end else begin
      dec_valid_q <= instr_valid;
      if (instr_valid) begin
        field1_q <= f1;
        field2_q <= f2;
        field3_q <= f3;
        field4_q <= f4;
        class_q <= cls_d;
        cond_q <= is_bicc ? cond_d : br_never;
        branch_annul_q <= is_bicc && instr[`RD_HI];
        rs1_q <= rs1;
        rs2_q <= rs2;
        rd_q <= f3;
        rs1_group_q <= g_rs1;
        rs2_group_q <= g_rs2;
        rd_group_q <= g_rd;
        rs1_zero_q <= z_rs1;
        rs2_zero_q <= z_rs2;
        rd_write_q <= rd_write_d;
        use_imm_q <= use_imm_d;
        imm_q <= imm_d;
        alt_space_q <= alt_d;
        asi_q <= alt_d ? instr[`ASI_HI:`ASI_LO] : 8'h00;
        asr_access_q <= asr_d;
        asr_illegal_q <= asr_bad_d;
      end
    end
  end

  // checks beside the logic
  chk_unimplemented_form_class: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h0
    |=> class_q == cls_unimplemented_form)
    else $error("unimplemented form not classified");
  chk_branch_cond: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h2
    |=> class_q == cls_branch && cond_q == branch_cond_t'($past(instr[28:25])))
    else $error("branch class or condition wrong");
  chk_cond_codes: assert property (@(posedge clk) disable iff (srst)
    class_q == cls_branch && field3_q[3:0] == 4'h9 |-> cond_q == br_ne)
    else $error("condition code mapping wrong");
  chk_cond_always: assert property (@(posedge clk) disable iff (srst)
    class_q == cls_branch && field3_q[3:0] == 4'h8 |-> cond_q == br_always)
    else $error("branch always mapping wrong");
  chk_fields_split: assert property (@(posedge clk) disable iff (srst)
    instr_valid |=> field4_q == $past(instr[13:5]) && field2_q == $past(instr[24:19]))
    else $error("field split wrong");
  chk_reg_group: assert property (@(posedge clk) disable iff (srst)
    dec_valid_q |-> rs1_group_q == reg_group_t'(rs1_q[4:3]))
    else $error("register group wrong");
  chk_asr_only17: assert property (@(posedge clk) disable iff (srst)
    asr_access_q |-> !asr_illegal_q && (field3_q == 5'h11 || rs1_q == 5'h11))
    else $error("ancillary register other than 17 accepted");
  chk_simm_sign: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31] && instr[13] |=> imm_q[31:12] == {20{imm_q[12]}})
    else $error("immediate not sign extended");
  chk_sethigh_low: assert property (@(posedge clk) disable iff (srst)
    class_q == cls_sethigh |-> imm_q[9:0] == 10'h000 && use_imm_q)
    else $error("set-high low bits not zero");
  chk_rd_zero: assert property (@(posedge clk) disable iff (srst)
    rd_q == 5'h00 |-> !rd_write_q)
    else $error("write to register zero not discarded");
  chk_ret_form: assert property (@(posedge clk) disable iff (srst)
    class_q == cls_ret |-> rs1_q == 5'h1f && rd_q == 5'h00 && imm_q == 32'h0000_0008)
    else $error("return form wrong");
  // word-level checks on the remaining fields and idioms
  chk_fields_upper: assert property (@(posedge clk) disable iff (srst)
    instr_valid |=> field1_q == $past(instr[31:30]) && field3_q == $past(instr[29:25]))
    else $error("upper field split wrong");
  chk_valid_follow: assert property (@(posedge clk) disable iff (srst)
    instr_valid |=> dec_valid_q)
    else $error("accepted word not marked valid");
  chk_annul_bit: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h2
    |=> branch_annul_q == $past(instr[29]))
    else $error("annul bit not carried");
  chk_cond_nonbranch: assert property (@(posedge clk) disable iff (srst)
    dec_valid_q && class_q != cls_branch |-> cond_q == br_never)
    else $error("condition shown for a non-branch word");
  chk_rd_group: assert property (@(posedge clk) disable iff (srst)
    dec_valid_q |-> rd_group_q == reg_group_t'(rd_q[4:3])
    && rs2_group_q == reg_group_t'(rs2_q[4:3]))
    else $error("rd or rs2 group wrong");
  chk_simm_value: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31] && instr[13] |=> imm_q[12:0] == $past(instr[12:0]))
    else $error("immediate low bits wrong");
  chk_sethigh_value: assert property (@(posedge clk) disable iff (srst)
    instr_valid && instr[31:30] == 2'h0 && instr[24:22] == 3'h4
    |=> imm_q[31:10] == $past(instr[21:0]))
    else $error("set-high constant not in upper bits");
  chk_asi_present: assert property (@(posedge clk) disable iff (srst)
    dec_valid_q |-> asi_q == (alt_space_q ? field4_q[7:0] : 8'h00))
    else $error("space identifier not presented");
  chk_retl_form: assert property (@(posedge clk) disable iff (srst)
    class_q == cls_retl |-> rs1_q == 5'h0f && rd_q == 5'h00 && imm_q == 32'h0000_0008)
    else $error("leaf return form wrong");
  chk_src_zero: assert property (@(posedge clk) disable iff (srst)
    dec_valid_q |-> rs1_zero_q == (rs1_q == 5'h00) && rs2_zero_q == (rs2_q == 5'h00))
    else $error("register zero flag wrong");
endmodule

// ==== verif/fetch_model.sv ====
// fetch stage stand-in that hands instruction words to the decoder
// assumes the bench asks for each word through req and req_word
`timescale 1ns/10ps
module fetch_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [31:0] req_word,
  output logic instr_valid,
  output logic [31:0] instr
);
  logic [31:0] last_q = 32'h0000_0000;
  // idle bus shows the inverse of the last word, so a stale word never decodes right
  assign instr_valid = req;
  assign instr = req ? req_word : ~last_q;
  // remember the last word handed over
  always_ff @(posedge clk) begin
    if (req) begin
      last_q <= req_word;
    end
  end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the instruction decode front end
// assumes the decoder answers one cycle after it takes a word
`timescale 1ns/10ps
module tb;
  import decode_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic [31:0] req_word = 32'h0000_0000;
  logic instr_valid, dec_valid_q, branch_annul_q, rs1_zero_q, rs2_zero_q, rd_write_q;
  logic use_imm_q, alt_space_q, asr_access_q, asr_illegal_q;
  logic [31:0] instr, imm_q;
  logic [1:0] field1_q;
  logic [5:0] field2_q;
  logic [4:0] field3_q, rs1_q, rs2_q, rd_q;
  logic [8:0] field4_q;
  logic [7:0] asi_q;
  instr_class_t class_q;
  branch_cond_t cond_q;
  reg_group_t rs1_group_q, rs2_group_q, rd_group_q;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  fetch_model fetch (.clk(clk), .req(req), .req_word(req_word), .instr_valid(instr_valid),
    .instr(instr));
  risc_format_branch_decoder DUT (.clk(clk), .srst(srst), .instr_valid(instr_valid),
    .instr(instr), .dec_valid_q(dec_valid_q), .field1_q(field1_q), .field2_q(field2_q),
    .field3_q(field3_q), .field4_q(field4_q), .class_q(class_q), .cond_q(cond_q),
    .branch_annul_q(branch_annul_q), .rs1_q(rs1_q), .rs2_q(rs2_q), .rd_q(rd_q),
    .rs1_group_q(rs1_group_q), .rs2_group_q(rs2_group_q), .rd_group_q(rd_group_q),
    .rs1_zero_q(rs1_zero_q), .rs2_zero_q(rs2_zero_q), .rd_write_q(rd_write_q),
    .use_imm_q(use_imm_q), .imm_q(imm_q), .alt_space_q(alt_space_q), .asi_q(asi_q),
    .asr_access_q(asr_access_q), .asr_illegal_q(asr_illegal_q));
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 80 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one word per call; request dropped at the taking edge so the answer is settled at #1
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    req <= 1'b1;
    req_word <= w;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  function automatic logic [31:0] f3(logic [1:0] op, logic [4:0] rd, logic [5:0] op3,
      logic [4:0] rs1, logic i, logic [12:0] lo);
    return {op, rd, op3, rs1, i, lo};
  endfunction
  task automatic t_fields();
    send(32'hdead_beef);
    chk("dec_valid", dec_valid_q, 1'b1);
    chk("field1", field1_q, 2'h3);
    chk("field2", field2_q, 6'h15);
    chk("field3", field3_q, 5'h0f);
    chk("field4", field4_q, 9'h1f7);
    @(posedge clk);
    #1;
    chk("dec_valid_drop", dec_valid_q, 1'b0);
    chk("field1_hold", field1_q, 2'h3);
  endtask
  task automatic t_unimplemented_form();
    send(32'h3e3f_ffff);
    chk("class_unimplemented_form", class_q, cls_unimplemented_form);
    chk("cond_nonbranch", cond_q, br_never);
  endtask
  task automatic t_branch();
    for (int c = 0; c < 16; c++) begin
      send({2'b00, c[0], c[3:0], 3'b010, 22'h2a_aaaa});
      chk("class_branch", class_q, cls_branch);
      chk("cond", cond_q, branch_cond_t'(c[3:0]));
      chk("annul", branch_annul_q, c[0]);
      if (c == 8) chk("cond_always", cond_q, br_always);
      if (c == 13) chk("cond_cc", cond_q, br_cc);
    end
  endtask
  task automatic t_regs();
    send({f3(2'h2, 5'h18, 6'h00, 5'h08, 1'b0, 13'h0000)} | 32'h0000_000f);
    chk("rs1_group", rs1_group_q, grp_out);
    chk("rs2_group", rs2_group_q, grp_out);
    chk("rd_group", rd_group_q, grp_in);
    chk("rd_write", rd_write_q, 1'b1);
    chk("rs1_num", rs1_q, 5'h08);
    chk("rs2_num", rs2_q, 5'h0f);
    chk("rd_num", rd_q, 5'h18);
    chk("rs2_nonzero", rs2_zero_q, 1'b0);
    send(f3(2'h2, 5'h00, 6'h00, 5'h00, 1'b0, 13'h0010));
    chk("rs1_zero", rs1_zero_q, 1'b1);
    chk("rd_zero_write", rd_write_q, 1'b0);
    chk("rs2_group_loc", rs2_group_q, grp_local);
  endtask
  task automatic t_asr();
    send(f3(2'h2, 5'h01, 6'h28, 5'h11, 1'b0, 13'h0000));
    chk("asr_rd17", asr_access_q, 1'b1);
    chk("asr_rd17_ok", asr_illegal_q, 1'b0);
    send(f3(2'h2, 5'h01, 6'h28, 5'h10, 1'b0, 13'h0000));
    chk("asr_rd16", asr_illegal_q, 1'b1);
    send(f3(2'h2, 5'h11, 6'h30, 5'h02, 1'b0, 13'h0000));
    chk("asr_wr17", asr_access_q, 1'b1);
  endtask
  task automatic t_imm();
    send(f3(2'h2, 5'h03, 6'h00, 5'h01, 1'b1, 13'h1000));
    chk("use_imm", use_imm_q, 1'b1);
    chk("imm_min", imm_q, 32'hffff_f000);
    send(f3(2'h2, 5'h03, 6'h00, 5'h01, 1'b1, 13'h0fff));
    chk("imm_max", imm_q, 32'h0000_0fff);
    send({2'b00, 5'h04, 3'b100, 22'h3f_ffff});
    chk("class_sethigh", class_q, cls_sethigh);
    chk("imm_high", imm_q, 32'hffff_fc00);
  endtask
  task automatic t_asi();
    send(f3(2'h3, 5'h02, 6'h10, 5'h01, 1'b0, 13'h1fe0));
    chk("alt_space", alt_space_q, 1'b1);
    chk("asi_max", asi_q, 8'hff);
    send(f3(2'h3, 5'h02, 6'h00, 5'h01, 1'b0, 13'h1fe0));
    chk("alt_space_off", alt_space_q, 1'b0);
  endtask
  task automatic t_ret();
    send(f3(2'h2, 5'h00, 6'h38, 5'h1f, 1'b1, 13'h0008));
    chk("class_ret", class_q, cls_ret);
    chk("ret_no_link", rd_write_q, 1'b0);
    send(f3(2'h2, 5'h00, 6'h38, 5'h0f, 1'b1, 13'h0008));
    chk("class_retl", class_q, cls_retl);
    send(f3(2'h2, 5'h00, 6'h38, 5'h0f, 1'b1, 13'h0004));
    chk("class_jump", class_q, cls_other);
  endtask
  // reset in mid-run clears the decode, then the next word decodes normally
  task automatic t_midreset();
    send(32'hdead_beef);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("mid_reset_field1", field1_q, 2'h0);
    chk("mid_reset_rs2_zero", rs2_zero_q, 1'b1);
    send(32'h3e3f_ffff);
    chk("after_reset_class", class_q, cls_unimplemented_form);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk("reset_class", class_q, cls_other);
    chk("reset_rs1_zero", rs1_zero_q, 1'b1);
    chk("reset_rs2_zero", rs2_zero_q, 1'b1);
    @(posedge clk);
    srst <= 1'b0;
    t_fields();
    t_unimplemented_form();
    t_branch();
    t_regs();
    t_asr();
    t_imm();
    t_asi();
    t_ret();
    t_midreset();
    end_sim();
  end
endmodule
